// *** design/cdaop_core.v ***
`default_nettype none
`include "cdaop_map.vh"
module cdaop_core (
  input wire sys_clk,
  input wire rst,
  input wire op_valid,
  input wire [1:0] op_sel,
  input wire [7:0] mem_rdata,
  input wire acc_load,
  input wire [7:0] acc_load_data,
  input wire flags_load,
  input wire carry_load_data,
  input wire half_carry_load_data,
  input wire zero_load_data,
  output reg [7:0] acc_q,
  output reg carry_flag_q,
  output reg half_carry_flag_q,
  output reg zero_flag_q,
  output reg mem_we_q,
  output reg [7:0] mem_wdata_q
);
  // one strobe for each operation of this block
  reg complement_memory_op;
  reg complement_to_accumulator_op;
  reg decimal_adjust_op;
  // both complement operations share one inverter
  wire [7:0] inv_byte;
  wire [7:0] bcd_res;
  wire bcd_carry;
  // an operation of this block takes priority over the core's direct loads
  wire acc_load_taken;
  wire zero_load_taken;
  wire carry_load_taken;
  reg [7:0] acc_d;
  reg carry_flag_d;
  reg half_carry_flag_d;
  reg zero_flag_d;
  reg mem_we_d;
  reg [7:0] mem_wdata_d;

  assign inv_byte = ~mem_rdata;

  // select code none leaves every strobe low
  always @*
  begin
    complement_memory_op = 1'h0;
    complement_to_accumulator_op = 1'h0;
    decimal_adjust_op = 1'h0;
    if (op_valid)
    begin
      case (op_sel)
        `CDAOP_COMPLEMENT_MEMORY_OP:
        begin
          complement_memory_op = 1'h1;
        end
        `CDAOP_COMPLEMENT_TO_ACCUMULATOR_OP:
        begin
          complement_to_accumulator_op = 1'h1;
        end
        `CDAOP_DECIMAL_ADJUST_OP:
        begin
          decimal_adjust_op = 1'h1;
        end
        default:
        begin
          decimal_adjust_op = 1'h0;
        end
      endcase
    end
  end

  cdaop_bcd_fix u_fix (
    .acc_in(acc_q),
    .carry_in(carry_flag_q),
    .half_carry_in(half_carry_flag_q),
    .result(bcd_res),
    .carry_out(bcd_carry)
  );

  // decimal adjust writes memory, not the accumulator, yet still owns the cycle
  assign acc_load_taken = acc_load && !decimal_adjust_op && !complement_memory_op;
  // adjust must leave zero alone, so a zero load beside it is dropped as well
  assign zero_load_taken = flags_load && !decimal_adjust_op;
  assign carry_load_taken = flags_load && !decimal_adjust_op &&
    !complement_memory_op && !complement_to_accumulator_op;

  always @*
  begin
    acc_d = acc_q;
    if (complement_to_accumulator_op)
    begin
      acc_d = inv_byte;
    end
    else if (acc_load_taken)
    begin
      acc_d = acc_load_data;
    end
  end

  always @*
  begin
    zero_flag_d = zero_flag_q;
    if (complement_memory_op || complement_to_accumulator_op)
    begin
      zero_flag_d = (inv_byte == 8'h00);
    end
    else if (zero_load_taken)
    begin
      zero_flag_d = zero_load_data;
    end
  end

  // adjust only ever sets carry; clearing it is left to a load
  always @*
  begin
    carry_flag_d = carry_flag_q;
    if (decimal_adjust_op)
    begin
      carry_flag_d = bcd_carry;
    end
    else if (carry_load_taken)
    begin
      carry_flag_d = carry_load_data;
    end
  end

  always @*
  begin
    half_carry_flag_d = half_carry_flag_q;
    if (carry_load_taken)
    begin
      half_carry_flag_d = half_carry_load_data;
    end
  end

  // the write strobe is high the cycle after each complement-memory or adjust cycle; data is refreshed every cycle
  always @*
  begin
    mem_we_d = complement_memory_op || decimal_adjust_op;
    mem_wdata_d = inv_byte;
    if (decimal_adjust_op)
    begin
      mem_wdata_d = bcd_res;
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      acc_q <= `CDAOP_ACC_RST;
    end
    else
    begin
      acc_q <= acc_d;
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      carry_flag_q <= `CDAOP_FLAG_RST;
    end
    else
    begin
      carry_flag_q <= carry_flag_d;
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      half_carry_flag_q <= `CDAOP_FLAG_RST;
    end
    else
    begin
      half_carry_flag_q <= half_carry_flag_d;
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      zero_flag_q <= `CDAOP_FLAG_RST;
    end
    else
    begin
      zero_flag_q <= zero_flag_d;
    end
  end

  // cleared in reset so memory is not written while the core starts up
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      mem_we_q <= `CDAOP_WE_RST;
    end
    else
    begin
      mem_we_q <= mem_we_d;
    end
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      mem_wdata_q <= `CDAOP_WDATA_RST;
    end
    else
    begin
      mem_wdata_q <= mem_wdata_d;
    end
  end
endmodule // cdaop_core
`default_nettype wire

// *** design/cdaop_map.vh ***
`ifndef CDAOP_MAP_VH
`define CDAOP_MAP_VH
// operation select codes
`define CDAOP_OP_NONE 2'h0
`define CDAOP_COMPLEMENT_MEMORY_OP 2'h1
`define CDAOP_COMPLEMENT_TO_ACCUMULATOR_OP 2'h2
`define CDAOP_DECIMAL_ADJUST_OP 2'h3
// decimal adjust constants
`define CDAOP_DIGIT_MAX 4'h9
`define CDAOP_ADJ_NONE 8'h00
`define CDAOP_ADJ_LOW 8'h06
`define CDAOP_ADJ_HIGH 8'h60
`define CDAOP_ADJ_BOTH 8'h66
// reset values
`define CDAOP_ACC_RST 8'h00
`define CDAOP_FLAG_RST 1'h0
`define CDAOP_WE_RST 1'h0
`define CDAOP_WDATA_RST 8'h00
`endif

// *** design/cdaop_bcd_fix.v ***
`default_nettype none
`include "cdaop_map.vh"
module cdaop_bcd_fix (
  input wire [7:0] acc_in,
  input wire carry_in,
  input wire half_carry_in,
  output reg [7:0] result,
  output reg carry_out
);
  reg fix_low;
  reg fix_high;
  reg [7:0] adj;
  always @*
  begin
    fix_low = (acc_in[3:0] > `CDAOP_DIGIT_MAX) || half_carry_in;
    // low-nibble add may push the high nibble past 9, so judge it on the adjusted value
    fix_high = (acc_in[7:4] > `CDAOP_DIGIT_MAX) || carry_in ||
      ((acc_in[7:4] == `CDAOP_DIGIT_MAX) && (acc_in[3:0] > `CDAOP_DIGIT_MAX));
    if (fix_low && fix_high)
      adj = `CDAOP_ADJ_BOTH;
    else if (fix_high)
      adj = `CDAOP_ADJ_HIGH;
    else if (fix_low)
      adj = `CDAOP_ADJ_LOW;
    else
      adj = `CDAOP_ADJ_NONE;
    // wraps past ff on purpose; the overflow lives in the carry flag
    result = acc_in + adj;
    carry_out = carry_in | fix_high;
  end
endmodule // cdaop_bcd_fix
`default_nettype wire

// *** bench/cdaop_chk_asserts.sv ***
`default_nettype none
module cdaop_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic op_valid,
  input wire logic [1:0] op_sel,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] acc_q,
  input wire logic carry_flag_q,
  input wire logic half_carry_flag_q,
  input wire logic zero_flag_q,
  input wire logic mem_we_q,
  input wire logic [7:0] mem_wdata_q
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  wire logic a = op_valid && op_sel == 2'h3;
  // adjust leaves acc alone, so acc after the edge is the adjusted source
  wire logic [7:0] d = mem_wdata_q - acc_q;
  wire logic [7:0] n = ~mem_rdata;
  // only the complement-memory and adjust codes have bit 0 set
  wire logic w = op_valid && op_sel[0];
  AST_COMPL_MEM: assert property (op_valid && op_sel == 2'h1 |=> mem_we_q && mem_wdata_q == $past(n))
    else $error("c1");
  AST_COMPL_ACC: assert property (op_valid && op_sel == 2'h2 |=> !mem_we_q && acc_q == $past(n))
    else $error("c2");
  AST_NO_STRAY_WRITE: assert property (mem_we_q |-> $past(w))
    else $error("w1");
  AST_ADJF: assert property (a |=> $stable(half_carry_flag_q))
    else $error("a6");
  AST_ADJW: assert property (a |=> mem_we_q && $stable(acc_q)) else $error("a1");
  AST_ADJL: assert property (a |=> d[3:0] == (acc_q[3:0] > 4'h9 || $past(half_carry_flag_q) ? 4'h6 : 4'h0))
    else $error("a2");
  AST_ADJH: assert property (a |=> d[7:4] == (acc_q > 8'h99 || $past(carry_flag_q) ? 4'h6 : 4'h0))
    else $error("a3");
  AST_ADJK: assert property (a |=> d inside {8'h00, 8'h06, 8'h60, 8'h66}) else $error("a4");
  AST_ADJC: assert property (a |=> carry_flag_q == ($past(carry_flag_q) || acc_q > 8'h99) && $stable(zero_flag_q))
    else $error("a5");
  AST_ZERO: assert property (op_valid && op_sel[0] != op_sel[1] |=> zero_flag_q == ($past(n) == 8'h00))
    else $error("z1");
endmodule // cdaop_chk
`default_nettype wire

// *** bench/cdaop_tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, rst = 1'h1, op_valid = 1'h0, acc_load = 1'h0, flags_load = 1'h0;
  logic carry_load_data = 1'h0, half_carry_load_data = 1'h0, zero_load_data = 1'h0;
  logic carry_flag_q, half_carry_flag_q, zero_flag_q, mem_we_q;
  logic [1:0] op_sel = 2'h0;
  logic [7:0] mem_rdata = 8'h00, acc_load_data = 8'h00, acc_q, mem_wdata_q;
  int failures = 0, total_checks = 0;
  always #4 sys_clk = ~sys_clk;
  cdaop_core dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .op_valid(op_valid),
    .op_sel(op_sel),
    .mem_rdata(mem_rdata),
    .acc_load(acc_load),
    .acc_load_data(acc_load_data),
    .flags_load(flags_load),
    .carry_load_data(carry_load_data),
    .half_carry_load_data(half_carry_load_data),
    .zero_load_data(zero_load_data),
    .acc_q(acc_q),
    .carry_flag_q(carry_flag_q),
    .half_carry_flag_q(half_carry_flag_q),
    .zero_flag_q(zero_flag_q),
    .mem_we_q(mem_we_q),
    .mem_wdata_q(mem_wdata_q)
  );
  task chk(input logic [9:0] g, e);
    total_checks++;
    failures += (g !== e);
    if (g !== e) $display("[FAIL] %0t %h %h", $time, g, e);
  endtask
  // f packs {acc, carry, half carry}; z is the zero flag loaded beside them
  task run(input logic [9:0] f, input logic z, input logic [1:0] s, input logic [7:0] r);
    @(posedge sys_clk);
    {acc_load, flags_load, acc_load_data, carry_load_data, half_carry_load_data, zero_load_data} <= {2'h3, f, z};
    @(posedge sys_clk);
    {acc_load, flags_load, op_valid, op_sel, mem_rdata} <= {3'h1, s, r};
    @(posedge sys_clk);
    op_valid <= 1'h0;
    #1;
  endtask
  task t_compl;
    run(10'h000, 1'h0, 2'h1, 8'hff);
    chk({mem_we_q, zero_flag_q, mem_wdata_q}, 10'h300);
    run(10'h000, 1'h1, 2'h2, 8'h0f);
    chk({mem_we_q, zero_flag_q, acc_q}, 10'h0f0);
    run(10'h3fc, 1'h0, 2'h2, 8'hff);
    chk({mem_we_q, zero_flag_q, acc_q}, 10'h100);
    run(10'h2a4, 1'h1, 2'h0, 8'h00);
    chk({mem_we_q, zero_flag_q, acc_q}, 10'h1a9);
  endtask
  task t_adj(input logic [9:0] f, e);
    run(f, 1'h1, 2'h3, 8'h00);
    chk({mem_we_q, carry_flag_q, mem_wdata_q}, e);
    chk({zero_flag_q, half_carry_flag_q, acc_q}, {1'h1, f[0], f[9:2]});
  endtask
  task test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    t_compl;
    t_adj(10'h114, 10'h245);
    t_adj(10'h055, 10'h21b);
    t_adj(10'h0f0, 10'h242);
    t_adj(10'h086, 10'h381);
    t_adj(10'h268, 10'h300);
    test_done;
  end
endmodule // tb
bind cdaop_core cdaop_chk chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .op_valid(op_valid),
  .op_sel(op_sel),
  .mem_rdata(mem_rdata),
  .acc_q(acc_q),
  .carry_flag_q(carry_flag_q),
  .half_carry_flag_q(half_carry_flag_q),
  .zero_flag_q(zero_flag_q),
  .mem_we_q(mem_we_q),
  .mem_wdata_q(mem_wdata_q)
);
`default_nettype wire
